//--- cid_pkg.sv
// constants for the interrupt dispatch block
// assumes an 8-bit register port and a sequencer instruction-cycle tick
package cid_pkg;
   // register port geometry
   localparam int DATA_W = 8;
   localparam int ADDR_W = 4;
   localparam int PC_W   = 15;
   // register offsets
   localparam logic [3:0] REG_CORE_CTRL  = 4'h0;
   localparam logic [3:0] REG_PFLAGS_A   = 4'h1;
   localparam logic [3:0] REG_PFLAGS_B   = 4'h2;
   localparam logic [3:0] REG_PFLAGS_C   = 4'h3;
   localparam logic [3:0] REG_PENABLES_A = 4'h4;
   localparam logic [3:0] REG_PENABLES_B = 4'h5;
   localparam logic [3:0] REG_PENABLES_C = 4'h6;
   localparam logic [3:0] REG_WAKE_MASK  = 4'h7;
   localparam logic [3:0] REG_EVT_STATUS = 4'h8;
   localparam logic [3:0] REG_EVT_CLEAR  = 4'h9;
   localparam logic [3:0] REG_EVT_ENABLE = 4'ha;
   // core control field positions
   localparam int CC_GIE      = 7;
   localparam int CC_PERIPHERAL_GROUP_IRQ_ENABLE     = 6;
   localparam int CC_EN_LSB   = 3;
   localparam int CC_FLAG_LSB = 0;
   localparam int N_CORE      = 3;
   localparam int N_BANK      = 3;
   // wake mask: core sources in low bits, peripheral banks above
   localparam int WM_BANK_LSB = 3;
   // event status bits
   localparam int EV_TAKEN  = 0;
   localparam int EV_RETURN = 1;
   localparam int EV_WAKE   = 2;
   localparam int N_EV      = 3;
   // reset values and the fixed handler entry
   localparam logic [7:0]  RST_ZERO    = 8'h00;
   localparam logic [14:0] VECTOR_ADDR = 15'h0004;
   // dispatch sequencer states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_FLUSH = 3'b010,
      ST_SAVE  = 3'b100
   } cid_state_t;
endpackage

//--- cid_dispatch.sv
// interrupt dispatch: flags, enables, request, core redirection sequence
// assumes a sequencer tick once per instruction cycle on clk_sys
`timescale 1ns/10ps

// Notes on behaviour
// R1 - any reset leaves every enable cleared, so no redirection occurs
// R2 - redirect only with global and own enable, peripheral group too
// R3 - flags set on events regardless of any enable bit
// R4 - taking an interrupt flushes the prefetch and clears global enable
// R5 - taking an interrupt pushes the program counter and saves shadows
// R6 - afterwards the program counter is loaded with the fixed vector
// R7 - return instruction pops address, restores shadows, sets global enable
// R8 - with global enable clear flags still set; serviced once re-enabled
// R9 - firmware clears serviced flags before returning or it re-triggers
// R10 - firmware polls flag bits to find the source of the shared vector
// R11 - synchronous sources reach the vector in three or four cycles
// R12 - asynchronous sources reach the vector in three to five cycles
// R13 - configured sources wake the core out of sleep
// R14 - request is OR of flag AND enable, peripheral banks group gated, then global gated
module cid_dispatch
   import cid_pkg::*;
(
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              nrst,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   // event sources
   input  wire logic              async_evt_pin,
   input  wire logic [1:0]        core_evt,
   input  wire logic [7:0]        periph_evt_a,
   input  wire logic [7:0]        periph_evt_b,
   input  wire logic [7:0]        periph_evt_c,
   // program sequencer
   input  wire logic              instr_tick,
   input  wire logic              core_sleeping,
   input  wire logic              return_from_handler_instr,
   output logic                   flush_prefetch,
   output logic                   push_pc,
   output logic                   shadow_save,
   output logic                   load_vector,
   output logic      [PC_W-1:0]   vector_addr,
   output logic                   pop_pc,
   output logic                   shadow_restore,
   output logic                   wake_req,
   // summary interrupt
   output logic                   irq
);

   // flag-and-enable reduction, used for dispatch and wake
   function automatic logic bank_pend(input logic [7:0] f, input logic [7:0] e);
      bank_pend = |(f & e);
   endfunction

   cid_state_t       state;
   logic             global_irq_enable;
   logic             peripheral_group_irq_enable;
   logic [N_CORE-1:0] core_en;
   logic [N_CORE-1:0] core_flag;
   logic [7:0]       pflag [N_BANK];
   logic [7:0]       pen [N_BANK];
   logic [7:0]       pevt [N_BANK];
   logic [7:0]       wake_mask;
   logic [N_EV-1:0]  evt_status;
   logic [N_EV-1:0]  evt_enable;
   logic             async_s1;
   logic             async_s2;
   logic             async_s3;
   logic [N_CORE-1:0] core_events;
   logic [N_BANK-1:0] bank_req;
   logic [N_BANK-1:0] bank_wake;
   logic             core_req;
   logic             irq_req;
   logic             take;
   logic             ret;
   logic             wake_now;
   logic             wr_ctrl;

   assign pevt[0] = periph_evt_a;
   assign pevt[1] = periph_evt_b;
   assign pevt[2] = periph_evt_c;

   // two-flop synchroniser for the asynchronous pin, edge found past it
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         async_s1 <= 1'b0;
         async_s2 <= 1'b0;
         async_s3 <= 1'b0;
      end
      else
      begin
         async_s1 <= async_evt_pin;
         async_s2 <= async_s1;
         async_s3 <= async_s2;
      end
   end

   // core source events: pin edge plus synchronous sources
   assign core_events = {core_evt, async_s2 & ~async_s3}; // R12

   // request forming per bank and overall
   generate
      for (genvar b = 0; b < N_BANK; b++)
      begin : g_bank
         assign bank_req[b]  = bank_pend(pflag[b], pen[b]);
         assign bank_wake[b] = bank_req[b] & wake_mask[WM_BANK_LSB + b];
      end
   endgenerate

   assign core_req = |(core_flag & core_en);
   assign irq_req  = global_irq_enable
                     & (core_req | (peripheral_group_irq_enable & |bank_req)); // R14 R2 R8
   assign take     = (state == ST_IDLE) & instr_tick & irq_req; // R11
   assign ret      = return_from_handler_instr & (state == ST_IDLE);
   assign wake_now = core_sleeping
                     & (|(core_flag & core_en & wake_mask[N_CORE-1:0])
                        | |bank_wake); // R13
   assign wr_ctrl  = reg_wr & (reg_addr == REG_CORE_CTRL);

   // dispatch sequencer: flush, then save, then jump, one step per instruction tick
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         state          <= ST_IDLE;
         flush_prefetch <= 1'b0;
         push_pc        <= 1'b0;
         shadow_save    <= 1'b0;
         load_vector    <= 1'b0;
      end
      else
      begin
         flush_prefetch <= 1'b0;
         push_pc        <= 1'b0;
         shadow_save    <= 1'b0;
         load_vector    <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               if (take)
               begin
                  flush_prefetch <= 1'b1; // R4
                  state          <= ST_FLUSH;
               end
            end
            ST_FLUSH:
            begin
               if (instr_tick)
               begin
                  push_pc     <= 1'b1; // R5
                  shadow_save <= 1'b1; // R5
                  state       <= ST_SAVE;
               end
            end
            ST_SAVE:
            begin
               if (instr_tick)
               begin
                  load_vector <= 1'b1; // R6
                  state       <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // vector address is fixed
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         vector_addr <= VECTOR_ADDR;
      else
         vector_addr <= VECTOR_ADDR; // R6
   end

   // return sequence pulses
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         pop_pc         <= 1'b0;
         shadow_restore <= 1'b0;
      end
      else
      begin
         pop_pc         <= ret; // R7
         shadow_restore <= ret; // R7
      end
   end

   // global and group enables; hardware take/return beat firmware writes
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         global_irq_enable           <= 1'b0; // R1
         peripheral_group_irq_enable <= 1'b0; // R1
         core_en                     <= '0;   // R1
      end
      else
      begin
         if (take)
            global_irq_enable <= 1'b0; // R4
         else if (ret)
            global_irq_enable <= 1'b1; // R7
         else if (wr_ctrl)
            global_irq_enable <= reg_wdata[CC_GIE];
         if (wr_ctrl)
         begin
            peripheral_group_irq_enable <= reg_wdata[CC_PERIPHERAL_GROUP_IRQ_ENABLE];
            core_en <= reg_wdata[CC_EN_LSB +: N_CORE];
         end
      end
   end

   // core flags: events set regardless of enables, set beats write
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         core_flag <= '0;
      else if (wr_ctrl)
         core_flag <= reg_wdata[CC_FLAG_LSB +: N_CORE] | core_events; // R3
      else
         core_flag <= core_flag | core_events; // R3 R8
   end

   // peripheral flag and enable banks
   generate
      for (genvar b = 0; b < N_BANK; b++)
      begin : g_pregs
         always_ff @(posedge clk_sys)
         begin
            if (!nrst)
            begin
               pflag[b] <= RST_ZERO;
               pen[b]   <= RST_ZERO; // R1
            end
            else
            begin
               if (reg_wr && reg_addr == REG_PFLAGS_A + 4'(b))
                  pflag[b] <= reg_wdata | pevt[b]; // R3
               else
                  pflag[b] <= pflag[b] | pevt[b]; // R3 R8
               if (reg_wr && reg_addr == REG_PENABLES_A + 4'(b))
                  pen[b] <= reg_wdata;
            end
         end
      end
   endgenerate

   // wake mask and wake request
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         wake_mask <= RST_ZERO;
         wake_req  <= 1'b0;
      end
      else
      begin
         if (reg_wr && reg_addr == REG_WAKE_MASK)
            wake_mask <= reg_wdata;
         wake_req <= wake_now; // R13
      end
   end

   // sticky event status, clear by write of ones, set wins
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         evt_status <= '0;
         evt_enable <= '0;
      end
      else
      begin
         if (reg_wr && reg_addr == REG_EVT_CLEAR)
            evt_status <= (evt_status & ~reg_wdata[N_EV-1:0])
                          | {wake_now, ret, take};
         else
            evt_status <= evt_status | {wake_now, ret, take};
         if (reg_wr && reg_addr == REG_EVT_ENABLE)
            evt_enable <= reg_wdata[N_EV-1:0];
      end
   end

   // summary interrupt level
   assign irq = |(evt_status & evt_enable);

   // read data, one cycle after the strobe, zero when unmapped
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         reg_rdata <= RST_ZERO;
      else if (reg_rd)
      begin
         case (reg_addr)
            REG_CORE_CTRL:
               reg_rdata <= {global_irq_enable, peripheral_group_irq_enable,
                             core_en, core_flag};
            REG_PFLAGS_A:   reg_rdata <= pflag[0];
            REG_PFLAGS_B:   reg_rdata <= pflag[1];
            REG_PFLAGS_C:   reg_rdata <= pflag[2];
            REG_PENABLES_A: reg_rdata <= pen[0];
            REG_PENABLES_B: reg_rdata <= pen[1];
            REG_PENABLES_C: reg_rdata <= pen[2];
            REG_WAKE_MASK:  reg_rdata <= wake_mask;
            REG_EVT_STATUS: reg_rdata <= {5'h00, evt_status};
            REG_EVT_ENABLE: reg_rdata <= {5'h00, evt_enable};
            default:        reg_rdata <= RST_ZERO;
         endcase
      end
      else
         reg_rdata <= RST_ZERO;
   end

endmodule

//--- cid_dispatch_monitor.sv
// assertions on the dispatch sequence outputs
// assumes one clock and a synchronous active low reset
`timescale 1ns/10ps
module cid_dispatch_monitor
   import cid_pkg::*;
(
   // clock, reset, sequencer
   input wire logic            clk_sys,
   input wire logic            nrst,
   input wire logic            instr_tick,
   input wire logic            core_sleeping,
   input wire logic            return_from_handler_instr,
   // dispatch outputs
   input wire logic            flush_prefetch,
   input wire logic            push_pc,
   input wire logic            shadow_save,
   input wire logic            load_vector,
   input wire logic [PC_W-1:0] vector_addr,
   input wire logic            pop_pc,
   input wire logic            shadow_restore,
   input wire logic            wake_req
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // sequence steps and their causes
   reset_quiet_a: assert property (!$past(nrst) |-> !(flush_prefetch | push_pc | load_vector | wake_req))
      else $error("output active right after reset");
   flush_tick_a: assert property (flush_prefetch |-> $past(instr_tick))
      else $error("flush without tick");
   no_reentry_a: assert property (flush_prefetch |=> (!flush_prefetch until load_vector))
      else $error("sequence re-entered");
   push_pair_a: assert property (push_pc |-> shadow_save && $past(instr_tick))
      else $error("push without shadow save or tick");
   seq_push_a: assert property (flush_prefetch |-> ##[1:16] push_pc)
      else $error("no push after flush");
   seq_load_a: assert property (push_pc |-> ##[1:16] load_vector)
      else $error("no vector load after push");
   load_vec_a: assert property (load_vector |-> vector_addr == VECTOR_ADDR && !push_pc)
      else $error("wrong vector");
   ret_pop_a: assert property (pop_pc |-> shadow_restore && $past(return_from_handler_instr))
      else $error("pop without return");
   wake_sleep_a: assert property (wake_req |-> $past(core_sleeping))
      else $error("wake while awake");
   // main scenarios reached
   cover property (load_vector);
   cover property (pop_pc);
   cover property (wake_req);
endmodule

bind cid_dispatch cid_dispatch_monitor u_mon (.clk_sys(clk_sys), .nrst(nrst), .instr_tick(instr_tick),
   .core_sleeping(core_sleeping), .return_from_handler_instr(return_from_handler_instr),
   .flush_prefetch(flush_prefetch), .push_pc(push_pc), .shadow_save(shadow_save), .load_vector(load_vector),
   .vector_addr(vector_addr), .pop_pc(pop_pc), .shadow_restore(shadow_restore), .wake_req(wake_req));

//--- cid_seq_model.sv
// sequencer stand-in: instruction tick, sleep level, return instructions
// assumes the bench toggles ret_go once per wanted return
`timescale 1ns/10ps
module cid_seq_model (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic nrst,
   // bench controls
   input  wire logic sleep_in,
   input  wire logic ret_go,
   // to the dispatch block
   output logic      instr_tick,
   output logic      core_sleeping,
   output logic      return_from_handler_instr
);
   logic ret_seen;
   // tick every second cycle, returns issued on a tick
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         instr_tick <= 1'b0;
         ret_seen <= 1'b0;
         return_from_handler_instr <= 1'b0;
      end
      else
      begin
         instr_tick <= !instr_tick;
         return_from_handler_instr <= !instr_tick && (ret_go != ret_seen);
         if (!instr_tick)
            ret_seen <= ret_go;
      end
      core_sleeping <= nrst && sleep_in;
   end
endmodule

//--- tb_cid_dispatch.sv
// self-checking bench for the interrupt dispatch block
// assumes cid_seq_model as sequencer, monitor bound in
`timescale 1ns/10ps
module tb_cid_dispatch
   import cid_pkg::*;
;
   logic [3:0]      reg_addr = '0;
   logic [7:0]      reg_wdata = '0, reg_rdata, pf_a = '0, pf_b = '0, pf_c = '0;
   logic [1:0]      cev = '0;
   logic            clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0, pin = 0, sleep_in = 0, ret_go = 0;
   logic            tick, sleeping, ret_i, flush, push, shsave, load, pop, shrest, wake, irq;
   logic [PC_W-1:0] vec;
   int              num_errors = 0, n_compared = 0, n_flush = 0, n_pop = 0;
   // clock and sequence counters
   always #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      n_flush <= n_flush + (flush === 1'b1);
      n_pop <= n_pop + (pop === 1'b1 && shrest === 1'b1); // pop and restore come together
   end
   cid_dispatch dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .async_evt_pin(pin), .core_evt(cev), .periph_evt_a(pf_a),
      .periph_evt_b(pf_b), .periph_evt_c(pf_c), .instr_tick(tick), .core_sleeping(sleeping),
      .return_from_handler_instr(ret_i), .flush_prefetch(flush), .push_pc(push), .shadow_save(shsave),
      .load_vector(load), .vector_addr(vec), .pop_pc(pop), .shadow_restore(shrest), .wake_req(wake), .irq(irq));
   cid_seq_model u_seq (.clk_sys(clk_sys), .nrst(nrst), .sleep_in(sleep_in), .ret_go(ret_go),
      .instr_tick(tick), .core_sleeping(sleeping), .return_from_handler_instr(ret_i));
   task automatic chk(input logic [14:0] got, input logic [14:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   // event, then count ticks until the vector is loaded
   task automatic lat(input bit on_pin, input int lo, input int hi);
      int n;
      logic [1:0] seen;
      n = 0;
      seen = 2'b00;
      @(posedge clk_sys);
      if (on_pin) pin <= 1'b1;
      else pf_a <= 8'h04;
      for (int t = 0; t < 60; t++)
      begin
         #1 if (tick === 1'b1) n++;
         @(posedge clk_sys);
         pf_a <= 8'h00;
         #1 seen = seen | {flush === 1'b1, push === 1'b1 && shsave === 1'b1};
         if (load === 1'b1) break;
      end
      chk(seen, 2'b11);
      chk(vec, VECTOR_ADDR);
      chk(n >= lo && n <= hi, 1'b1);
   endtask
   task automatic t_reset;
      rd(REG_CORE_CTRL, 8'h00);
      rd(REG_PENABLES_A, 8'h00);
      rd(4'hf, 8'h00);
      chk(irq, 1'b0);
   endtask
   task automatic t_flags;
      @(posedge clk_sys);
      pf_b <= 8'h81;
      pf_c <= 8'h10;
      cev <= 2'b01;
      @(posedge clk_sys);
      pf_b <= 8'h00;
      pf_c <= 8'h00;
      cev <= 2'b00;
      rd(REG_PFLAGS_B, 8'h81);
      rd(REG_PFLAGS_C, 8'h10);
      rd(REG_CORE_CTRL, 8'h02);
      wr(REG_PENABLES_B, 8'h01);
      wr(REG_CORE_CTRL, 8'h80);
      repeat (20) @(posedge clk_sys);
      chk(n_flush, 0);
      wr(REG_PFLAGS_B, 8'h00);
      wr(REG_PFLAGS_C, 8'h00);
      wr(REG_CORE_CTRL, 8'h00);
   endtask
   task automatic t_take;
      wr(REG_PENABLES_A, 8'h04);
      wr(REG_EVT_ENABLE, 8'h01);
      wr(REG_CORE_CTRL, 8'hc0);
      lat(1'b0, 3, 4);
      rd(REG_CORE_CTRL, 8'h40);
      rd(REG_PFLAGS_A, 8'h04);
      rd(REG_EVT_STATUS, 8'h01);
      chk(irq, 1'b1);
      wr(REG_EVT_CLEAR, 8'h01);
      #1 chk(irq, 1'b0);
   endtask
   task automatic t_retrig;
      repeat (20) @(posedge clk_sys);
      chk(n_flush, 1);
      ret_go <= ~ret_go;
      repeat (20) @(posedge clk_sys);
      chk(n_pop, 1);
      chk(n_flush, 2);
      wr(REG_PFLAGS_A, 8'h00);
      @(posedge clk_sys);
      ret_go <= ~ret_go;
      repeat (20) @(posedge clk_sys);
      chk(n_flush, 2);
      rd(REG_CORE_CTRL, 8'hc0);
   endtask
   task automatic t_async_wake;
      wr(REG_PENABLES_A, 8'h00);
      wr(REG_CORE_CTRL, 8'h88);
      lat(1'b1, 3, 5);
      @(posedge clk_sys);
      pin <= 1'b0;
      wr(REG_CORE_CTRL, 8'h00);
      wr(REG_EVT_CLEAR, 8'h07);
      wr(REG_WAKE_MASK, 8'h08);
      wr(REG_PENABLES_A, 8'h04);
      @(posedge clk_sys);
      sleep_in <= 1'b1;
      pf_a <= 8'h04;
      @(posedge clk_sys);
      pf_a <= 8'h00;
      repeat (4) @(posedge clk_sys);
      #1 chk(wake, 1'b1);
      rd(REG_EVT_STATUS, 8'h04);
   endtask
   // reset in mid-run while a request is pending and the sequence may be busy
   task automatic t_rereset;
      wr(REG_CORE_CTRL, 8'hf8);
      @(posedge clk_sys);
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      rd(REG_CORE_CTRL, 8'h00);
      rd(REG_PENABLES_A, 8'h00);
      rd(REG_WAKE_MASK, 8'h00);
      chk(wake, 1'b0);
      chk(irq, 1'b0);
   endtask
   task automatic wrap_up;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // main sequence
   initial
   begin
      repeat (6) @(posedge clk_sys);
      nrst <= 1'b1;
      t_reset;
      t_flags;
      t_take;
      t_retrig;
      t_async_wake;
      t_rereset;
      wrap_up;
   end
   // watchdog
   initial
   begin
      #20000;
      num_errors++;
      wrap_up;
   end
endmodule
